/* File: rtl/dpsi_pkg.sv */
package dpsi_pkg;

    // ----------------------------------------
    // Widths and counts
    // ----------------------------------------
    localparam int DPSI_DATA_W = 8;
    localparam int DPSI_POTS = 2;
    localparam int DPSI_REGS = 4;
    localparam int DPSI_TAPS = 256;
    localparam int DPSI_NV_AW = 3;
    localparam int DPSI_PIN_W = 7;

    // ----------------------------------------
    // Timing
    // ----------------------------------------
    localparam int DPSI_CLK_PERIOD_NS = 10;
    localparam int DPSI_WRITE_TIME_NS = 5000000;
    localparam int DPSI_WRITE_CYCLES = (DPSI_WRITE_TIME_NS / DPSI_CLK_PERIOD_NS < 1) ? 1 :
        DPSI_WRITE_TIME_NS / DPSI_CLK_PERIOD_NS;

    // ----------------------------------------
    // Reset values
    // ----------------------------------------
    // Pin order: cs_n, sck, si, hold_n, wp_n, addr_pin_high, addr_pin_low
    localparam logic [6:0] DPSI_PIN_RST = 7'h4C;
    localparam logic [7:0] DPSI_NV_INIT = 8'h80;
    localparam logic [7:0] DPSI_WIPER_RST = 8'h00;
    localparam logic [2:0] DPSI_LAST_BIT = 3'h7;

    // ----------------------------------------
    // Instruction byte layout
    // ----------------------------------------
    localparam int DPSI_OP_MSB = 7;
    localparam int DPSI_OP_LSB = 5;
    localparam int DPSI_ADR_MSB = 4;
    localparam int DPSI_ADR_LSB = 3;
    localparam int DPSI_POT_BIT = 2;
    localparam int DPSI_IDX_MSB = 1;
    localparam int DPSI_IDX_LSB = 0;

    // ----------------------------------------
    // Opcodes
    // ----------------------------------------
    localparam logic [2:0] DPSI_OP_RD_WIPER = 3'h1;
    localparam logic [2:0] DPSI_OP_WR_WIPER = 3'h2;
    localparam logic [2:0] DPSI_OP_RD_STORE = 3'h3;
    localparam logic [2:0] DPSI_OP_WR_STORE = 3'h4;
    localparam logic [2:0] DPSI_OP_SAVE = 3'h5;
    localparam logic [2:0] DPSI_OP_RECALL = 3'h6;

    typedef enum logic [3:0] {
        DPSI_ST_IDLE = 4'h1,
        DPSI_ST_INSTR = 4'h2,
        DPSI_ST_DATA = 4'h4,
        DPSI_ST_SKIP = 4'h8
    } dpsi_state_e;

    function automatic logic [DPSI_TAPS-1:0] dpsi_tap_decode(input logic [DPSI_DATA_W-1:0] v);
        dpsi_tap_decode = '0;
        dpsi_tap_decode[v] = 1'b1;
    endfunction : dpsi_tap_decode

endpackage : dpsi_pkg

/* File: rtl/dpsi_sync.sv */
`timescale 1ns/1ps
`default_nettype none
module dpsi_sync import dpsi_pkg::*; #(
    parameter int W = DPSI_PIN_W,
    parameter logic [W-1:0] RST_VAL = '0
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    // ----------------------------------------
    // Two-stage synchroniser, first stage read only by the second
    // ----------------------------------------
    logic [W-1:0] meta;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            meta <= RST_VAL;
            q <= RST_VAL;
        end else if (ce) begin
            meta <= d;
            q <= meta;
        end
    end
endmodule : dpsi_sync
`default_nettype wire

/* File: rtl/dpsi_nv_store.sv */
`timescale 1ns/1ps
`default_nettype none
module dpsi_nv_store import dpsi_pkg::*; #(
    parameter int WRITE_CYCLES = DPSI_WRITE_CYCLES
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic launch,
    input wire logic [DPSI_NV_AW-1:0] launch_addr,
    input wire logic [DPSI_DATA_W-1:0] launch_data,
    input wire logic [DPSI_NV_AW-1:0] rd_addr,
    output logic [DPSI_DATA_W-1:0] rd_data,
    output logic busy
);
    localparam int CNT_W = $clog2(WRITE_CYCLES + 1);

    // ----------------------------------------
    // Storage, deliberately not cleared by reset
    // ----------------------------------------
    // Start contents stand for an erased store; only the write process owns it afterwards
    logic [DPSI_DATA_W-1:0] stored_setting_reg [DPSI_POTS*DPSI_REGS] = '{default: DPSI_NV_INIT};
    logic [DPSI_NV_AW-1:0] wr_addr;
    logic [DPSI_DATA_W-1:0] wr_data;
    logic [CNT_W-1:0] cnt;

    assign rd_data = stored_setting_reg[rd_addr];

    // ----------------------------------------
    // Write cycle: once running, only reset stops it
    // ----------------------------------------
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            busy <= 1'b0;
            cnt <= '0;
            wr_addr <= '0;
            wr_data <= '0;
        end else if (ce) begin
            if (!busy && launch) begin
                busy <= 1'b1;
                cnt <= CNT_W'(WRITE_CYCLES - 1);
                wr_addr <= launch_addr;
                wr_data <= launch_data;
            end else if (busy && cnt == '0) begin
                busy <= 1'b0;
            end else if (busy) begin
                cnt <= cnt - 1'b1; // [RL8]
            end
        end
    end

    always_ff @(posedge clk) begin
        if (ce && busy && cnt == '0) begin
            stored_setting_reg[wr_addr] <= wr_data; // [RL14]
        end
    end

    AST_NV_RUNS_OUT: assert property (@(posedge clk) disable iff (!rst_n) // [RL8]
        (ce && busy && cnt != '0) |=> busy && cnt == $past(cnt) - 1'b1)
        else $error("write cycle stopped early");

endmodule : dpsi_nv_store
`default_nettype wire

/* File: rtl/dpsi_top.sv */
// Operation
// RL1 - Sample serial input on rising clock edges
// RL2 - Shift read data out on falling edges
// RL3 - Select low enables; high floats, standby; code keeps standby low while a write cycle runs
// RL4 - Master starts every command with select falling
// RL5 - Write cycle starts at select rise only
// RL6 - Write-protect low blocks stored writes only
// RL7 - Protect falling during select aborts write
// RL8 - Launched write cycle always completes
// RL9 - Master enters hold only with clock low
// RL10 - Hold floats output, freezes sequence state
// RL11 - Master leaves hold with clock low
// RL12 - Respond only when address matches pins
// RL13 - Power-up copies first stored setting
// RL14 - One wiper, four stored bytes per pot
// RL15 - Wiper value selects exactly one tap
// RL16 - First byte is the instruction byte
// RL17 - Drive output only while returning read data
`timescale 1ns/1ps
`default_nettype none
module dpsi_top import dpsi_pkg::*; #(
    parameter int WRITE_CYCLES = DPSI_WRITE_CYCLES
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic cs_n,
    input wire logic sck,
    input wire logic si,
    input wire logic hold_n,
    input wire logic wp_n,
    input wire logic addr_pin_low,
    input wire logic addr_pin_high,
    output logic so,
    output logic so_oe,
    output logic standby,
    output logic write_busy,
    output logic [DPSI_DATA_W-1:0] wiper_setting_reg_0,
    output logic [DPSI_DATA_W-1:0] wiper_setting_reg_1,
    output logic [DPSI_TAPS-1:0] tap_sel_0,
    output logic [DPSI_TAPS-1:0] tap_sel_1
);

    // ----------------------------------------
    // Pin synchronisation and edges
    // ----------------------------------------
    logic [DPSI_PIN_W-1:0] pins_s;
    logic s_cs_n, s_sck, s_si, s_hold_n, s_wp_n, s_a1, s_a0;
    logic sck_d, cs_d, wp_d;
    logic sck_rise, sck_fall, cs_fall, cs_rise, wp_fall;

    dpsi_sync #(.W(DPSI_PIN_W), .RST_VAL(DPSI_PIN_RST)) u_sync (
        .clk(clk),
        .rst_n(rst_n),
        .ce(ce),
        .d({cs_n, sck, si, hold_n, wp_n, addr_pin_high, addr_pin_low}),
        .q(pins_s)
    );

    assign {s_cs_n, s_sck, s_si, s_hold_n, s_wp_n, s_a1, s_a0} = pins_s;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            sck_d <= 1'b0;
            cs_d <= 1'b1;
            wp_d <= 1'b1;
        end else if (ce) begin
            sck_d <= s_sck;
            cs_d <= s_cs_n;
            wp_d <= s_wp_n;
        end
    end

    assign sck_rise = s_sck & ~sck_d;
    assign sck_fall = ~s_sck & sck_d;
    assign cs_fall = ~s_cs_n & cs_d;
    assign cs_rise = s_cs_n & ~cs_d;
    assign wp_fall = ~s_wp_n & wp_d;

    // ----------------------------------------
    // Hold pause
    // ----------------------------------------
    // Hold is only looked at while the clock is low, so a hold
    // edge in the clock-high phase waits for the next low phase.
    logic paused;
    logic adv;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            paused <= 1'b0;
        end else if (ce) begin
            if (s_cs_n) begin
                paused <= 1'b0;
            end else if (!s_sck) begin
                paused <= ~s_hold_n; // [RL10]
            end
        end
    end

    assign adv = ~s_cs_n & ~paused; // [RL10]

    // ----------------------------------------
    // Bit and byte framing
    // ----------------------------------------
    dpsi_state_e state;
    logic [2:0] bit_cnt;
    logic [DPSI_DATA_W-1:0] shift_in;
    logic [DPSI_DATA_W-1:0] next_byte;
    logic [DPSI_DATA_W-1:0] instr;
    logic byte_done;
    logic [2:0] op;
    logic addr_ok, op_ok, op_rd, nv_busy;

    assign next_byte = {shift_in[DPSI_DATA_W-2:0], s_si};
    assign byte_done = adv & sck_rise & (bit_cnt == DPSI_LAST_BIT);
    assign op = next_byte[DPSI_OP_MSB:DPSI_OP_LSB];
    assign addr_ok = next_byte[DPSI_ADR_MSB:DPSI_ADR_LSB] == {s_a1, s_a0};
    // Stored-register commands are refused while a write cycle runs
    assign op_ok = (op == DPSI_OP_RD_WIPER) || (op == DPSI_OP_WR_WIPER) || (op == DPSI_OP_RECALL && !nv_busy) ||
        ((op == DPSI_OP_RD_STORE || op == DPSI_OP_WR_STORE || op == DPSI_OP_SAVE) && !nv_busy);
    assign op_rd = (op == DPSI_OP_RD_WIPER) || (op == DPSI_OP_RD_STORE);

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            bit_cnt <= '0;
            shift_in <= '0;
        end else if (ce) begin
            if (cs_fall) begin
                bit_cnt <= '0;
            end else if (adv && sck_rise) begin
                bit_cnt <= bit_cnt + 1'b1;
                shift_in <= next_byte; // [RL1]
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state <= DPSI_ST_IDLE;
        end else if (ce) begin
            if (s_cs_n) begin
                state <= DPSI_ST_IDLE; // [RL3]
            end else if (cs_fall) begin
                state <= DPSI_ST_INSTR; // [RL4]
            end else if (byte_done) begin
                unique case (state)
                    DPSI_ST_IDLE: state <= DPSI_ST_IDLE;
                    DPSI_ST_INSTR: state <= (addr_ok && op_ok) ? DPSI_ST_DATA : DPSI_ST_SKIP; // [RL12]
                    DPSI_ST_DATA: state <= DPSI_ST_SKIP;
                    DPSI_ST_SKIP: state <= DPSI_ST_SKIP;
                    default: state <= DPSI_ST_IDLE;
                endcase
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            instr <= '0;
        end else if (ce && byte_done && state == DPSI_ST_INSTR) begin
            instr <= next_byte; // [RL16]
        end
    end

    // ----------------------------------------
    // Wiper registers and power-up recall
    // ----------------------------------------
    logic [DPSI_DATA_W-1:0] wiper_setting_reg [DPSI_POTS];
    logic recalling;
    logic recall_ptr;
    logic [DPSI_NV_AW-1:0] rd_addr;
    logic [DPSI_DATA_W-1:0] nv_rd_data;
    logic cmd_pot;

    assign cmd_pot = next_byte[DPSI_POT_BIT];
    // Recall owns the read port for two cycles after reset
    assign rd_addr = recalling ? {recall_ptr, 2'h0} : next_byte[DPSI_POT_BIT:DPSI_IDX_LSB];

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            recalling <= 1'b1;
            recall_ptr <= 1'b0;
        end else if (ce && recalling) begin
            recall_ptr <= 1'b1;
            recalling <= ~recall_ptr;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            wiper_setting_reg[0] <= DPSI_WIPER_RST;
            wiper_setting_reg[1] <= DPSI_WIPER_RST;
        end else if (ce) begin
            if (recalling) begin
                wiper_setting_reg[recall_ptr] <= nv_rd_data; // [RL13]
            end else if (byte_done && state == DPSI_ST_INSTR && addr_ok && op_ok && op == DPSI_OP_RECALL) begin
                wiper_setting_reg[cmd_pot] <= nv_rd_data;
            end else if (byte_done && state == DPSI_ST_DATA && instr[DPSI_OP_MSB:DPSI_OP_LSB] == DPSI_OP_WR_WIPER) begin
                wiper_setting_reg[instr[DPSI_POT_BIT]] <= next_byte; // [RL6]
            end
        end
    end

    assign wiper_setting_reg_0 = wiper_setting_reg[0];
    assign wiper_setting_reg_1 = wiper_setting_reg[1];

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            tap_sel_0 <= '0;
            tap_sel_1 <= '0;
        end else if (ce) begin
            tap_sel_0 <= dpsi_tap_decode(wiper_setting_reg[0]); // [RL15]
            tap_sel_1 <= dpsi_tap_decode(wiper_setting_reg[1]); // [RL15]
        end
    end

    // ----------------------------------------
    // Pending stored write and launch
    // ----------------------------------------
    logic pend;
    logic [DPSI_NV_AW-1:0] pend_addr;
    logic [DPSI_DATA_W-1:0] pend_data;
    logic nv_launch;

    assign nv_launch = cs_rise & pend & s_wp_n & ~nv_busy; // [RL5]

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pend <= 1'b0;
            pend_addr <= '0;
            pend_data <= '0;
        end else if (ce) begin
            if (cs_fall || cs_rise) begin
                pend <= 1'b0;
            end else if (!s_cs_n && wp_fall) begin
                pend <= 1'b0; // [RL7]
            end else if (byte_done && s_wp_n && state == DPSI_ST_INSTR && addr_ok && op_ok && op == DPSI_OP_SAVE) begin
                pend <= 1'b1; // [RL6]
                pend_addr <= next_byte[DPSI_POT_BIT:DPSI_IDX_LSB];
                pend_data <= wiper_setting_reg[cmd_pot];
            end else if (byte_done && s_wp_n && state == DPSI_ST_DATA &&
                    instr[DPSI_OP_MSB:DPSI_OP_LSB] == DPSI_OP_WR_STORE) begin
                pend <= 1'b1; // [RL6]
                pend_addr <= instr[DPSI_POT_BIT:DPSI_IDX_LSB];
                pend_data <= next_byte;
            end
        end
    end

    dpsi_nv_store #(.WRITE_CYCLES(WRITE_CYCLES)) u_nv (
        .clk(clk),
        .rst_n(rst_n),
        .ce(ce),
        .launch(nv_launch),
        .launch_addr(pend_addr),
        .launch_data(pend_data),
        .rd_addr(rd_addr),
        .rd_data(nv_rd_data),
        .busy(nv_busy)
    );

    assign write_busy = nv_busy;
    assign standby = s_cs_n & ~nv_busy; // [RL3]

    // ----------------------------------------
    // Serial output
    // ----------------------------------------
    logic rd_phase;
    logic [DPSI_DATA_W-1:0] so_sh;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rd_phase <= 1'b0;
            so_sh <= '0;
            so <= 1'b0;
        end else if (ce) begin
            if (s_cs_n) begin
                rd_phase <= 1'b0;
            end else if (byte_done && state == DPSI_ST_INSTR) begin
                rd_phase <= addr_ok && op_ok && op_rd;
                so_sh <= (op == DPSI_OP_RD_WIPER) ? wiper_setting_reg[cmd_pot] : nv_rd_data;
            end else if (adv && sck_fall && rd_phase && state == DPSI_ST_DATA) begin
                so <= so_sh[DPSI_DATA_W-1]; // [RL2]
                so_sh <= {so_sh[DPSI_DATA_W-2:0], 1'b0};
            end
        end
    end

    // Drive only in the data byte of a read; a bit stays on the pin
    // until the next synchronised falling edge or the last rising one.
    assign so_oe = rd_phase & (state == DPSI_ST_DATA) & adv; // [RL17]

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    sequence s_byte_in;
        ce && byte_done && state == DPSI_ST_INSTR;
    endsequence

    sequence s_recall_end;
        ce && recalling && recall_ptr;
    endsequence

    AST_SAMPLE_RISE: assert property ((ce && adv && sck_rise) |=> shift_in[0] == $past(s_si)) // [RL1]
        else $error("input bit not taken on rising edge");

    AST_SO_ON_FALL: assert property ((ce && so != $past(so)) |-> $past(sck_fall && adv)) // [RL2]
        else $error("output changed away from a falling edge");

    AST_CS_HIGH_IDLE: assert property (s_cs_n |-> !so_oe ##1 (!ce || state == DPSI_ST_IDLE)) // [RL3]
        else $error("deselected device still active");

    AST_LAUNCH_AT_RISE: assert property ((ce && $rose(nv_busy)) |-> $past(cs_rise && pend && s_cs_n)) // [RL5]
        else $error("write cycle launched outside select rise");

    AST_WP_BLOCKS: assert property ((ce && !s_wp_n) |=> !$rose(nv_busy)) // [RL6]
        else $error("stored write launched while protected");

    AST_WP_ABORT: assert property ((ce && !s_cs_n && wp_fall) |=> !pend ##1 !nv_launch) // [RL7]
        else $error("pending write survived protect fall");

    AST_HOLD_FREEZE: assert property ((ce && paused) |-> !so_oe ##1 (bit_cnt == $past(bit_cnt))) // [RL10]
        else $error("paused device moved on");

    AST_ADDR_MISMATCH: assert property ((s_byte_in and (!addr_ok)) |=> state == DPSI_ST_SKIP) // [RL12]
        else $error("command for another address accepted");

    AST_RECALL: assert property (s_recall_end |=> !recalling && wiper_setting_reg[1] == $past(nv_rd_data)) // [RL13]
        else $error("power-up recall not copied");

    AST_ONE_TAP: assert property ((ce && rst_n) |=> $onehot(tap_sel_0) && tap_sel_0[$past(wiper_setting_reg[0])]) // [RL15]
        else $error("tap select not one-hot");

    AST_INSTR_LOAD: assert property (s_byte_in |=> instr == $past(next_byte)) // [RL16]
        else $error("instruction byte not held");

endmodule : dpsi_top
`default_nettype wire

/* File: tb/dpsi_spi_master.sv */
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Serial bus master model
// ----------------------------------------
module dpsi_spi_master #(
    parameter int HALF = 8
) (
    input wire logic clk,
    input wire logic so,
    input wire logic so_oe,
    output logic cs_n,
    output logic sck,
    output logic si,
    output logic hold_n
);
    initial begin
        cs_n = 1'b1;
        sck = 1'b0;
        si = 1'b0;
        hold_n = 1'b1;
    end

    // Slow sck keeps every phase outside a hold pause well clear of the pin synchroniser latency
    task automatic xfer(input logic [15:0] bits, input int hold_bit, output logic [7:0] rd,
                        output logic [16:0] oe);
        oe = '0;
        rd = '0;
        @(posedge clk) cs_n <= 1'b0;
        for (int i = 15; i >= 0; i--) begin
            repeat (HALF) @(posedge clk);
            sck <= 1'b0;
            si <= bits[i];
            if (i == hold_bit) begin
                repeat (4) @(posedge clk);
                hold_n <= 1'b0;
                repeat (2) @(posedge clk);
                // Clock and data pulses while paused must be ignored
                repeat (HALF) @(posedge clk) begin
                    si <= ~si;
                    sck <= ~sck;
                end
                @(negedge clk) oe[16] = so_oe;
                @(posedge clk) begin
                    si <= bits[i];
                    hold_n <= 1'b1;
                end
            end
            repeat (HALF - 1) @(posedge clk);
            @(negedge clk);
            oe[i] = so_oe;
            if (i < 8) begin
                rd[i] = so;
            end
            @(posedge clk) sck <= 1'b1;
        end
        repeat (HALF) @(posedge clk);
        sck <= 1'b0;
        repeat (4) @(posedge clk);
        cs_n <= 1'b1;
        // Released data line must not look like a held bit
        si <= ~si;
        repeat (HALF) @(posedge clk);
    endtask : xfer
endmodule : dpsi_spi_master
`default_nettype wire

/* File: tb/tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tb;
    import dpsi_pkg::*;
    localparam int WC = 20;
    logic clk, rst_n, wp_n, cs_n, sck, si, hold_n, so, so_oe, standby, write_busy, busy_in_frame;
    logic [1:0] adr;
    logic [DPSI_DATA_W-1:0] wiper_setting_reg_0, wiper_setting_reg_1;
    logic [DPSI_TAPS-1:0] tap_sel_0, tap_sel_1;
    logic [7:0] rd;
    logic [16:0] oe;
    int miscompares, comparisons;

    dpsi_top #(.WRITE_CYCLES(WC)) u_dut (.clk(clk), .rst_n(rst_n), .ce(1'b1), .cs_n(cs_n), .sck(sck),
        .si(si), .hold_n(hold_n), .wp_n(wp_n), .addr_pin_low(adr[0]), .addr_pin_high(adr[1]),
        .so(so), .so_oe(so_oe), .standby(standby), .write_busy(write_busy),
        .wiper_setting_reg_0(wiper_setting_reg_0), .wiper_setting_reg_1(wiper_setting_reg_1),
        .tap_sel_0(tap_sel_0), .tap_sel_1(tap_sel_1));
    dpsi_spi_master u_master (.clk(clk), .so(so), .so_oe(so_oe), .cs_n(cs_n), .sck(sck), .si(si),
        .hold_n(hold_n));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    always @(posedge clk) begin
        if (!rst_n) begin
            busy_in_frame <= 1'b0;
        end else if (!cs_n && write_busy) begin
            busy_in_frame <= 1'b1;
        end
    end

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    task chk(input string name, input logic [255:0] exp, input logic [255:0] got);
        // Look away from the launching edge so outputs are settled
        @(negedge clk);
        comparisons++;
        if (got !== exp) begin
            miscompares++;
            $display("Error %s expected %0h seen %0h", name, exp, got);
        end
    endtask : chk

    task results;
        if (miscompares == 0 && comparisons > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : results

    task do_reset;
        @(posedge clk) rst_n <= 1'b0;
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        repeat (6) @(posedge clk);
    endtask : do_reset

    task cmd(input logic [2:0] op, input logic [1:0] a, input logic pot, input logic [1:0] idx,
             input logic [7:0] d, input int hb = -1);
        u_master.xfer({op, a, pot, idx, d}, hb, rd, oe);
    endtask : cmd

    task wait_write;
        for (int k = 0; k < 4 * WC && write_busy !== 1'b0; k++) begin
            @(posedge clk);
        end
        if (write_busy !== 1'b0) begin
            miscompares++;
            results();
        end
    endtask : wait_write

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task s_power_up(input logic [7:0] exp0);
        chk("wiper_setting_reg_0", exp0, wiper_setting_reg_0);
        chk("wiper_setting_reg_1", DPSI_NV_INIT, wiper_setting_reg_1);
        chk("tap_sel_0", 256'h1 << exp0, tap_sel_0);
        chk("standby", 1'b1, standby);
        chk("so_oe", 1'b0, so_oe);
    endtask : s_power_up

    task s_wiper;
        for (int p = 0; p < 2; p++) begin
            cmd(DPSI_OP_WR_WIPER, adr, p[0], 2'h0, 8'h5A + 8'(p));
            chk("oe_write", 17'h0, oe);
            cmd(DPSI_OP_RD_WIPER, adr, p[0], 2'h0, 8'h00);
            chk("read_wiper", 8'h5A + 8'(p), rd);
            chk("oe_read", 17'h000FF, oe);
        end
        chk("wiper_setting_reg_1", 8'h5B, wiper_setting_reg_1);
        chk("tap_sel_1", 256'h1 << 8'h5B, tap_sel_1);
    endtask : s_wiper

    task s_address;
        for (int a = 0; a < 4; a++) begin
            @(posedge clk) adr <= 2'(a);
            repeat (4) @(posedge clk);
            cmd(DPSI_OP_WR_WIPER, 2'(a), 1'b0, 2'h0, 8'h10 + 8'(a));
            cmd(DPSI_OP_WR_WIPER, 2'(a) ^ 2'h1, 1'b0, 2'h0, 8'hEE);
            chk("wiper_setting_reg_0", 8'h10 + 8'(a), wiper_setting_reg_0);
        end
    endtask : s_address

    task s_stored;
        cmd(DPSI_OP_WR_STORE, adr, 1'b1, 2'h2, 8'hC3);
        chk("write_busy", 1'b1, write_busy);
        chk("standby", 1'b0, standby);
        @(posedge clk) wp_n <= 1'b0;
        wait_write();
        @(posedge clk) wp_n <= 1'b1;
        repeat (4) @(posedge clk);
        cmd(DPSI_OP_RD_STORE, adr, 1'b1, 2'h2, 8'h00);
        chk("read_store", 8'hC3, rd);
        chk("busy_in_frame", 1'b0, busy_in_frame);
        chk("standby", 1'b1, standby);
    endtask : s_stored

    task s_protect;
        @(posedge clk) wp_n <= 1'b0;
        repeat (4) @(posedge clk);
        cmd(DPSI_OP_WR_STORE, adr, 1'b0, 2'h1, 8'h3C);
        chk("write_busy", 1'b0, write_busy);
        cmd(DPSI_OP_WR_WIPER, adr, 1'b0, 2'h0, 8'h77);
        chk("wiper_setting_reg_0", 8'h77, wiper_setting_reg_0);
        @(posedge clk) wp_n <= 1'b1;
        repeat (4) @(posedge clk);
        cmd(DPSI_OP_RD_STORE, adr, 1'b0, 2'h1, 8'h00);
        chk("read_store", DPSI_NV_INIT, rd);
    endtask : s_protect

    task s_abort;
        fork
            cmd(DPSI_OP_WR_STORE, adr, 1'b0, 2'h3, 8'h99);
            begin
                // Fall after the data byte is taken, rise again before select rises
                repeat (261) @(posedge clk);
                wp_n <= 1'b0;
                repeat (5) @(posedge clk);
                wp_n <= 1'b1;
            end
        join
        chk("write_busy", 1'b0, write_busy);
        cmd(DPSI_OP_RD_STORE, adr, 1'b0, 2'h3, 8'h00);
        chk("read_store", DPSI_NV_INIT, rd);
    endtask : s_abort

    task s_hold;
        cmd(DPSI_OP_WR_WIPER, adr, 1'b1, 2'h0, 8'hA5, 3);
        cmd(DPSI_OP_RD_WIPER, adr, 1'b1, 2'h0, 8'h00, 4);
        chk("read_wiper", 8'hA5, rd);
        chk("oe_hold", 17'h000FF, oe);
    endtask : s_hold

    task s_save_recall;
        cmd(DPSI_OP_SAVE, adr, 1'b0, 2'h0, 8'h00);
        wait_write();
        cmd(DPSI_OP_WR_WIPER, adr, 1'b0, 2'h0, 8'h01);
        cmd(DPSI_OP_RECALL, adr, 1'b0, 2'h0, 8'h00);
        chk("wiper_setting_reg_0", 8'h77, wiper_setting_reg_0);
        do_reset();
        s_power_up(8'h77);
    endtask : s_save_recall

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        rst_n = 1'b0;
        wp_n = 1'b1;
        adr = 2'h2;
        miscompares = 0;
        comparisons = 0;
        do_reset();
        s_power_up(DPSI_NV_INIT);
        s_wiper();
        s_address();
        s_stored();
        s_protect();
        s_abort();
        s_hold();
        s_save_recall();
        results();
    end
endmodule : tb
`default_nettype wire
